// ===== pkg/flash_port_pkg.sv
`default_nettype none
package flash_port_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // link framing and flash geometry
  localparam int          UNIT_BITS      = 8;
  localparam int          PAGE_BYTES     = 256;
  localparam int          ID_BYTES       = 7;
  localparam logic [7:0]  PAGE_LAST      = 8'(PAGE_BYTES - 1);
  localparam logic [7:0]  ID_LAST        = 8'(ID_BYTES - 1);
  localparam int          BOOT_BYTES     = 8192;
  localparam logic [23:0] BOOT_FIRST     = 24'h0F_E000;
  localparam logic [23:0] BOOT_LAST      = 24'h0F_FFFF;
  localparam int          CLK_PERIOD_NS  = 10;

  ////////////////////////////////////////////////////////////////////////////
  // command codes
  localparam logic [7:0]  CMD_PAGE_READ    = 8'hFF;
  localparam logic [7:0]  CMD_PAGE_PROG    = 8'h41;
  localparam logic [7:0]  CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0]  CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0]  CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0]  CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0]  CMD_ID_CHECK     = 8'hF5;

  ////////////////////////////////////////////////////////////////////////////
  // status byte layout
  localparam logic [7:0]  STATUS_RESET   = 8'h80;
  localparam int          READY_BIT      = 7;
  localparam int          ERASE_ERR_BIT  = 5;
  localparam int          PROG_ERR_BIT   = 4;
  localparam int          AFTER_PROG_BIT = 3;

  // command sequencer states
  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_ARGS   = 5'b00010,
    S_STREAM = 5'b00100,
    S_ID     = 5'b01000,
    S_WAIT   = 5'b10000
  } seq_state_t;

endpackage : flash_port_pkg
`default_nettype wire

// ===== hdl/pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // a bit moves only where the second and third stages agree
  assign agree = ~(stage2 ^ stage3);

  // three stages, left free-running so straps are seen during reset
  always_ff @(posedge i_clk) begin
    stage1 <= i_d;
    stage2 <= stage1;
    stage3 <= stage2;
    o_q    <= (agree & stage3) | (~agree & o_q);
  end

endmodule : pin_filter
`default_nettype wire

// ===== hdl/serial_flash_programming_port.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - boot area is one eight kilobyte region apart from the user area
// - boot area erases as one block covering all eight kilobytes
// - serial mode entered only with chip enable high, program strap low, mode pin high
// - transfer clock level at reset release picks synchronous or asynchronous mode
// - synchronous mode uses clock, receive, transmit and busy pins
// - asynchronous mode uses only receive and transmit, no clock or busy handshake
// - inbound bits are captured on the transfer clock rising edge
// - outbound bits are launched on the transfer clock falling edge
// - data moves in eight bit units, least significant bit first
// - busy low when ready to receive, high once reception begins
// - busy high during transmit, receive, erase or program
// - serial mode refuses program or erase aimed at the boot area
// - non-blank flash rejects commands until seven byte id code matches
// - asynchronous mode busy pin reports the program operation check
// - status byte resets to ready with all error flags clear
// - read status returns primary then secondary status byte
// - page read returns 256 bytes from the fourth transfer, lowest address first
module serial_flash_programming_port
  import flash_port_pkg::*;
#(
  parameter int          BIT_TIME_NS = 1000,
  parameter logic [15:0] BIT_CLKS    = 16'(BIT_TIME_NS / CLK_PERIOD_NS)
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_SRST,
  input  wire logic        I_CHIP_ENABLE_STRAP,
  input  wire logic        I_PROGRAM_MODE_STRAP,
  input  wire logic        I_PROCESSOR_MODE_PIN,
  input  wire logic        I_TRANSFER_CLOCK_PIN,
  input  wire logic        I_SERIAL_RECEIVE_PIN,
  input  wire logic        I_FLASH_BLANK,
  input  wire logic [55:0] I_STORED_ID,
  input  wire logic [7:0]  I_FLASH_RDATA,
  input  wire logic        I_FLASH_DONE,
  input  wire logic        I_FLASH_FAIL,
  output logic             O_SERIAL_TRANSMIT_PIN,
  output logic             O_BUSY_HANDSHAKE_PIN,
  output logic             O_SERIAL_ACTIVE,
  output logic             O_SYNC_MODE,
  output logic [23:0]      O_FLASH_ADDR,
  output logic [7:0]       O_FLASH_WDATA,
  output logic             O_FLASH_RD,
  output logic             O_FLASH_WR,
  output logic             O_FLASH_PROG,
  output logic             O_FLASH_ERASE
);

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling and strap capture
  logic [4:0] pins_f;
  logic       clk_f, rx_f, clk_d, rx_d, rst_d;
  logic       serial_active, sync_mode;

  // clock and receive pins in, transmit and busy out; the clock is only sampled, never driven
  pin_filter #(.WIDTH(5)) u_pins (
    .i_clk (I_MCLK),
    .i_d   ({I_CHIP_ENABLE_STRAP, I_PROGRAM_MODE_STRAP, I_PROCESSOR_MODE_PIN,
             I_TRANSFER_CLOCK_PIN, I_SERIAL_RECEIVE_PIN}),
    .o_q   (pins_f)
  );
  assign clk_f = pins_f[1];
  assign rx_f  = pins_f[0];

  // straps caught on the first cycle after release; filter settled during reset
  always_ff @(posedge I_MCLK) begin
    rst_d <= I_SRST;
    clk_d <= clk_f;
    rx_d  <= rx_f;
    if (I_SRST) begin
      serial_active <= 1'b0;
      sync_mode     <= 1'b0;
    end else if (rst_d) begin
      serial_active <= pins_f[4] & ~pins_f[3] & pins_f[2];
      sync_mode     <= clk_f;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bit engine: clocked by host edges in mode 1, by a bit timer in mode 2
  logic        clk_rise, clk_fall, a_tick, a_start, a_rx_bit, a_tx_bit;
  logic        last_in, a_tx_end, unit_done, tx_lsb;
  logic [3:0]  bit_cnt, a_phase;
  logic [15:0] a_cnt;
  logic        a_busy, a_dir;
  logic [7:0]  rx_shift, tx_shift, rx_byte, tx_data;
  logic        tx_load;

  // edge and tick decode; no clock use in mode 2
  assign clk_rise  = serial_active & sync_mode & clk_f & ~clk_d;
  assign clk_fall  = serial_active & sync_mode & ~clk_f & clk_d;
  assign a_tick    = a_busy & (a_cnt == 16'h0000);
  assign a_start   = serial_active & ~sync_mode & ~a_busy & ~rx_f & rx_d & ~tx_load;
  assign a_rx_bit  = a_tick & ~a_dir & (a_phase != 4'h0);
  assign a_tx_bit  = a_tick & a_dir & (a_phase < 4'h8);
  assign last_in   = (clk_rise & (bit_cnt == 4'h7)) | (a_rx_bit & (a_phase == 4'h8));
  assign a_tx_end  = a_tick & a_dir & (a_phase == 4'h9);
  assign unit_done = last_in | a_tx_end;
  assign rx_byte   = {rx_f, rx_shift[7:1]};
  assign tx_lsb    = tx_shift[0];

  // rising edge count per unit and serial capture, lsb first
  always_ff @(posedge I_MCLK) begin
    if (I_SRST | ~serial_active) begin
      bit_cnt  <= 4'h0;
      rx_shift <= 8'hFF;
    end else begin
      if (clk_rise)
        bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
      if (clk_rise | a_rx_bit)
        rx_shift <= rx_byte;
    end
  end

  // mode 2 bit timer: half bit to the start centre, then whole bits
  always_ff @(posedge I_MCLK) begin
    if (I_SRST | ~serial_active | sync_mode) begin
      a_busy  <= 1'b0;
      a_dir   <= 1'b0;
      a_phase <= 4'h0;
      a_cnt   <= 16'h0000;
    end else if (tx_load) begin
      a_busy  <= 1'b1;
      a_dir   <= 1'b1;
      a_phase <= 4'h0;
      a_cnt   <= BIT_CLKS - 16'h0001;
    end else if (a_start) begin
      a_busy  <= 1'b1;
      a_dir   <= 1'b0;
      a_phase <= 4'h0;
      a_cnt   <= (BIT_CLKS >> 1);
    end else if (a_tick) begin
      a_cnt   <= BIT_CLKS - 16'h0001;
      a_phase <= a_phase + 4'h1;
      if (a_phase == (a_dir ? 4'h9 : 4'h8))
        a_busy <= 1'b0;
    end else if (a_busy) begin
      a_cnt <= a_cnt - 16'h0001;
    end
  end

  // transmit shifter: bits leave on falling edges, or on timer ticks in mode 2
  always_ff @(posedge I_MCLK) begin
    if (I_SRST | ~serial_active) begin
      tx_shift              <= 8'hFF;
      O_SERIAL_TRANSMIT_PIN <= 1'b1;
    end else if (tx_load) begin
      tx_shift <= tx_data;
      if (!sync_mode)
        O_SERIAL_TRANSMIT_PIN <= 1'b0;            // start bit
    end else if (clk_fall | a_tx_bit) begin
      O_SERIAL_TRANSMIT_PIN <= tx_shift[0];
      tx_shift              <= {1'b1, tx_shift[7:1]};
    end else if (a_tick & a_dir) begin
      O_SERIAL_TRANSMIT_PIN <= 1'b1;              // stop bit
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // command sequencer
  seq_state_t  state;
  logic [7:0]  cmd, cnt, status, status_two, id_byte;
  logic [2:0]  arg_idx, args_needed;
  logic [23:0] addr, next_addr;
  logic        id_ok, id_checked, id_match, refuse, rd_pend, rd_take;
  logic        locked, cmd_open, arg_last, addr_arg, boot_now, boot_next, fsm_ready;

  // decode of gate, arguments and boot area
  assign locked      = ~I_FLASH_BLANK & ~id_ok;
  assign cmd_open    = (rx_byte == CMD_READ_STATUS) | (rx_byte == CMD_ID_CHECK);
  assign args_needed = (cmd == CMD_ID_CHECK) ? 3'd4 : (cmd == CMD_BLOCK_ERASE) ? 3'd3 : 3'd2;
  assign arg_last    = (arg_idx == args_needed - 3'd1);
  assign addr_arg    = arg_idx < ((cmd == CMD_ID_CHECK) ? 3'd3 : 3'd2);
  assign next_addr   = {rx_byte, addr[23:8]};
  assign boot_now    = (addr >= BOOT_FIRST) & (addr <= BOOT_LAST);
  assign boot_next   = (next_addr >= BOOT_FIRST) & (next_addr <= BOOT_LAST);
  assign id_byte     = I_STORED_ID[{cnt[2:0], 3'b000} +: 8];
  assign status_two  = {6'h00, id_checked, id_ok};

  // busy handshake: unit activity in mode 1, flash check in mode 2
  assign fsm_ready = (state != S_WAIT) & ~rd_pend & ~O_FLASH_RD & ~rd_take & ~unit_done & ~tx_load;
  assign O_BUSY_HANDSHAKE_PIN = ~serial_active |
    (sync_mode ? (~fsm_ready | (bit_cnt != 4'h0) | a_busy) : (state == S_WAIT));
  assign O_SERIAL_ACTIVE = serial_active;
  assign O_SYNC_MODE     = sync_mode;

  // sequencer: command, arguments, page stream, id compare and flash wait
  always_ff @(posedge I_MCLK) begin
    if (I_SRST | ~serial_active) begin
      state <= S_IDLE;
      status <= STATUS_RESET;
      {cmd, cnt, arg_idx, addr, tx_data, O_FLASH_WDATA} <= '0;
      {id_ok, id_checked, id_match, refuse, rd_pend, rd_take, tx_load} <= '0;
      {O_FLASH_ADDR, O_FLASH_RD, O_FLASH_WR, O_FLASH_PROG, O_FLASH_ERASE} <= '0;
    end else begin
      O_FLASH_RD    <= rd_pend;
      rd_take       <= O_FLASH_RD;
      rd_pend       <= 1'b0;
      tx_load       <= rd_take;
      O_FLASH_WR    <= 1'b0;
      O_FLASH_PROG  <= 1'b0;
      O_FLASH_ERASE <= 1'b0;
      if (rd_pend)
        O_FLASH_ADDR <= addr;
      if (rd_take)
        tx_data <= I_FLASH_RDATA;
      case (state)
        S_IDLE: if (unit_done & ~(locked & ~cmd_open)) begin
          cmd <= rx_byte;
          addr <= 24'h00_0000;
          arg_idx <= 3'd0;
          cnt <= 8'h00;
          case (rx_byte)
            CMD_READ_STATUS: begin
              tx_load <= 1'b1;
              tx_data <= status;
              state   <= S_STREAM;
            end
            CMD_CLEAR_STATUS: begin
              status[ERASE_ERR_BIT]  <= 1'b0;
              status[PROG_ERR_BIT]   <= 1'b0;
              status[AFTER_PROG_BIT] <= 1'b0;
            end
            CMD_PAGE_READ, CMD_PAGE_PROG, CMD_BLOCK_ERASE, CMD_ID_CHECK:
              state <= S_ARGS;
            default: ;
          endcase
        end
        S_ARGS: if (unit_done) begin
          arg_idx <= arg_idx + 3'd1;
          if (addr_arg)
            addr <= next_addr;
          if (arg_last) begin
            case (cmd)
              CMD_PAGE_READ: begin
                rd_pend <= 1'b1;
                state   <= S_STREAM;
              end
              CMD_PAGE_PROG: begin
                refuse <= boot_next;
                state  <= S_STREAM;
              end
              CMD_BLOCK_ERASE: if ((rx_byte == CMD_CONFIRM) & ~boot_now) begin
                O_FLASH_ERASE <= 1'b1;
                O_FLASH_ADDR  <= addr;
                state         <= S_WAIT;
              end else begin
                status[ERASE_ERR_BIT] <= 1'b1;
                status[PROG_ERR_BIT]  <= 1'b1;
                state                 <= S_IDLE;
              end
              default: begin
                id_match <= 1'b1;
                state    <= S_ID;
              end
            endcase
          end
        end
        S_STREAM: if (unit_done) begin
          cnt <= cnt + 8'h01;
          addr[7:0] <= addr[7:0] + 8'h01;
          if (cmd == CMD_READ_STATUS) begin
            if (cnt == 8'h00) begin
              tx_load <= 1'b1;
              tx_data <= status_two;
            end else
              state <= S_IDLE;
          end else if (cmd == CMD_PAGE_PROG) begin
            if (!refuse) begin
              O_FLASH_WR    <= 1'b1;
              O_FLASH_ADDR  <= addr;
              O_FLASH_WDATA <= rx_byte;
            end
            if (cnt == PAGE_LAST) begin
              if (refuse) begin
                status[PROG_ERR_BIT] <= 1'b1;
                state                <= S_IDLE;
              end else begin
                O_FLASH_PROG <= 1'b1;
                state        <= S_WAIT;
              end
            end
          end else if (cnt == PAGE_LAST)
            state <= S_IDLE;
          else
            rd_pend <= 1'b1;
        end
        S_ID: if (unit_done) begin
          cnt <= cnt + 8'h01;
          if (rx_byte != id_byte)
            id_match <= 1'b0;
          if (cnt == ID_LAST) begin
            id_ok      <= id_match & (rx_byte == id_byte);
            id_checked <= 1'b1;
            state      <= S_IDLE;
          end
        end
        S_WAIT: if (I_FLASH_DONE) begin
          if (I_FLASH_FAIL)
            status[(cmd == CMD_BLOCK_ERASE) ? ERASE_ERR_BIT : PROG_ERR_BIT] <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);

  sequence status_cmd_s;
    (state == S_IDLE) && unit_done && (rx_byte == CMD_READ_STATUS);
  endsequence

  busy_on_rx_a: assert property (serial_active && sync_mode && bit_cnt != 4'h0 |-> O_BUSY_HANDSHAKE_PIN)
    else $error("busy low during a unit");
  busy_on_wait_a: assert property (state == S_WAIT |-> O_BUSY_HANDSHAKE_PIN)
    else $error("busy low during flash work");
  unit_count_a: assert property (clk_rise && bit_cnt == 4'h7 |-> unit_done ##1 bit_cnt == 4'h0)
    else $error("unit not closed on eighth edge");
  launch_hold_a: assert property (serial_active && sync_mode && !clk_fall |=> $stable(O_SERIAL_TRANSMIT_PIN))
    else $error("transmit pin moved off a falling edge");
  lsb_out_a: assert property (clk_fall |=> O_SERIAL_TRANSMIT_PIN == $past(tx_lsb))
    else $error("transmit bit order wrong");
  status_reset_a: assert property ($past(I_SRST) |-> status == STATUS_RESET)
    else $error("status not ready after reset");
  status_pair_a: assert property (status_cmd_s |=> tx_load && tx_data == status ##1 state == S_STREAM)
    else $error("primary status not loaded");
  boot_guard_a: assert property (O_FLASH_WR || O_FLASH_PROG || O_FLASH_ERASE |-> O_FLASH_ADDR < BOOT_FIRST || O_FLASH_ADDR > BOOT_LAST)
    else $error("flash change aimed at boot area");
  id_gate_a: assert property (state == S_IDLE && unit_done && locked && !cmd_open |=> state == S_IDLE && !tx_load)
    else $error("locked command accepted");
  async_busy_a: assert property (serial_active && !sync_mode |-> O_BUSY_HANDSHAKE_PIN == (state == S_WAIT))
    else $error("mode 2 busy not tracking flash check");
  idle_pins_a: assert property (!serial_active |-> O_BUSY_HANDSHAKE_PIN && O_SERIAL_TRANSMIT_PIN)
    else $error("pins active outside serial mode");

endmodule : serial_flash_programming_port
`default_nettype wire

// ===== sim/flash_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// external programmer: makes the transfer clock, drives receive data, samples transmit data
module flash_host_model (
  input  wire logic i_clk,
  input  wire logic i_busy,
  input  wire logic i_tx,
  output logic      o_sclk,
  output logic      o_rx,
  output logic      o_busy_mid
);
  initial begin
    o_sclk     = 1'b1;
    o_rx       = 1'b1;
    o_busy_mid = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one unit each way; clock idles high and stands still between units
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    while (i_busy !== 1'b0) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      o_sclk = 1'b0;
      o_rx   = d[i];
      #62.5;
      o_sclk = 1'b1;
      q[i]   = i_tx;
      #62.5;
      if (i == 3) o_busy_mid = i_busy;
    end
    // released data line must not keep the last bit
    o_rx = ~d[7];
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // mode 2: one frame out, then n_out frames back; the clock pin is left alone
  task automatic uart_xfer(input logic [7:0] d, input int n_out, output logic [15:0] q);
    q    = 16'hFFFF;
    o_rx = 1'b0;                                // start bit
    for (int i = 0; i < 8; i++) begin
      #160;
      o_rx = d[i];
    end
    // the reply may begin inside the last data bit, so listen from there
    if (n_out == 0)
      #160;
    else
      @(negedge i_tx);
    o_rx = 1'b1;                                // stop bit, then idle
    if (n_out == 0)
      #160;
    for (int b = 0; b < n_out; b++) begin
      if (b > 0)
        @(negedge i_tx);
      #80;
      for (int i = 0; i < 8; i++) begin
        #160;
        q[8*b+i] = i_tx;
      end
    end
    // let the last stop bit pass before the next frame
    if (n_out > 0)
      #320;
  endtask : uart_xfer
endmodule : flash_host_model
`default_nettype wire

// ===== sim/test_serial_flash_programming_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_programming_port;
  import flash_port_pkg::*;
  logic        mclk = 1'b0, srst = 1'b1, ce = 1'b1, program_mode_strap = 1'b0, cnv = 1'b1;
  logic        blank = 1'b0, fail = 1'b0, done = 1'b0;
  logic [7:0]  rdata = 8'h00, q;
  logic [55:0] id = 56'h12_3456_789A_BCDE;
  logic        sclk, rx, tx, busy, act, sync, rd, wr, prog, erase, busy_mid;
  logic [23:0] addr;
  logic [7:0]  wdata;
  int          fail_count = 0, comparisons = 0, cycles = 0, rd_n = 0, wr_n = 0, prog_n = 0, er_n = 0;
  logic [4:0]  wait_n = 5'h00;

  always #5 mclk = ~mclk;

  serial_flash_programming_port #(.BIT_TIME_NS(160)) u_dut (
    .I_MCLK(mclk), .I_SRST(srst), .I_CHIP_ENABLE_STRAP(ce), .I_PROGRAM_MODE_STRAP(program_mode_strap),
    .I_PROCESSOR_MODE_PIN(cnv), .I_TRANSFER_CLOCK_PIN(sclk), .I_SERIAL_RECEIVE_PIN(rx),
    .I_FLASH_BLANK(blank), .I_STORED_ID(id), .I_FLASH_RDATA(rdata), .I_FLASH_DONE(done),
    .I_FLASH_FAIL(fail), .O_SERIAL_TRANSMIT_PIN(tx), .O_BUSY_HANDSHAKE_PIN(busy),
    .O_SERIAL_ACTIVE(act), .O_SYNC_MODE(sync), .O_FLASH_ADDR(addr), .O_FLASH_WDATA(wdata),
    .O_FLASH_RD(rd), .O_FLASH_WR(wr), .O_FLASH_PROG(prog), .O_FLASH_ERASE(erase));

  flash_host_model u_host (.i_clk(mclk), .i_busy(busy), .i_tx(tx), .o_sclk(sclk), .o_rx(rx),
    .o_busy_mid(busy_mid));

  ////////////////////////////////////////////////////////////////////////////
  // flash array stand-in: read data follows address, done answers program or erase
  always @(negedge mclk) begin
    rdata  <= addr[7:0] ^ 8'hA5;
    done   <= (wait_n == 5'h01);
    wait_n <= (prog | erase) ? 5'h1F : ((wait_n != 5'h00) ? wait_n - 5'h01 : wait_n);
  end

  // pulse counters, write data check, run ceiling
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    rd_n   <= rd_n + int'(rd);
    prog_n <= prog_n + int'(prog);
    er_n   <= er_n + int'(erase);
    if (wr === 1'b1) begin
      wr_n <= wr_n + 1;
      check(addr, {16'h0056, 8'(wr_n)});
      check(24'(wdata), 24'(8'(wr_n) ^ 8'h3C));
    end
    if (cycles == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic byte_io(input logic [7:0] d);
    u_host.xfer(d, q);
  endtask : byte_io

  task automatic reset_dut(input logic [2:0] straps, input logic clk_level);
    @(negedge mclk);
    srst = 1'b1;
    {ce, program_mode_strap, cnv} = straps;
    u_host.o_sclk = clk_level;
    repeat (25) @(negedge mclk);
    srst = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : reset_dut

  task automatic status(input logic [7:0] exp_p, input logic [7:0] exp_s);
    byte_io(CMD_READ_STATUS);
    check(24'(busy_mid), 24'h00_0001);
    byte_io(8'h00);
    check(24'(q), 24'(exp_p));
    byte_io(8'h00);
    check(24'(q), 24'(exp_s));
  endtask : status

  ////////////////////////////////////////////////////////////////////////////
  // strap combinations and mode choice at reset release
  task automatic t_modes();
    logic [2:0] combo [4] = '{3'b101, 3'b001, 3'b111, 3'b100};
    foreach (combo[i]) begin
      reset_dut(combo[i], 1'b0);
      check(24'(act), 24'(combo[i] == 3'b101));
      check(24'(sync), 24'h00_0000);
    end
    check(24'(busy), 24'h00_0001);
    reset_dut(3'b101, 1'b1);
    check(24'({act, sync, busy, tx}), 24'h00_000D);
  endtask : t_modes

  // id gate on non-blank flash: refusal, wrong code, right code
  task automatic t_gate();
    int base;
    base = rd_n;
    status(STATUS_RESET, 8'h00);
    byte_io(CMD_PAGE_READ);
    byte_io(8'h00);
    byte_io(8'h01);
    repeat (20) @(negedge mclk);
    check(24'(rd_n - base), 24'h00_0000);
    for (int k = 0; k < 2; k++) begin
      byte_io(CMD_ID_CHECK);
      repeat (3) byte_io(8'h00);
      byte_io(8'h07);
      for (int b = 0; b < 7; b++) byte_io(id[8*b +: 8] ^ ((k == 0 && b == 6) ? 8'h01 : 8'h00));
      status(STATUS_RESET, (k == 0) ? 8'h02 : 8'h03);
    end
  endtask : t_gate

  // full page read, lowest address first
  task automatic t_read();
    int base;
    base = rd_n;
    byte_io(CMD_PAGE_READ);
    byte_io(8'h34);
    byte_io(8'h00);
    for (int i = 0; i < 256; i++) begin
      byte_io(8'h00);
      check(24'(q), 24'(8'(i) ^ 8'hA5));
    end
    check(24'(rd_n - base), 24'h00_0100);
    check(24'(addr[23:8]), 24'h00_0034);
  endtask : t_read

  // page program ending in a flash fault, then clear status
  task automatic t_prog();
    fail = 1'b1;
    byte_io(CMD_PAGE_PROG);
    byte_io(8'h56);
    byte_io(8'h00);
    for (int i = 0; i < 256; i++) byte_io(8'(i) ^ 8'h3C);
    check(24'(busy), 24'h00_0001);
    check(24'(wr_n), 24'h00_0100);
    check(24'(prog_n), 24'h00_0001);
    status(8'h90, 8'h03);
    fail = 1'b0;
    byte_io(CMD_CLEAR_STATUS);
    status(STATUS_RESET, 8'h03);
  endtask : t_prog

  // boot area erase is refused, user block erase goes through
  task automatic t_erase();
    int base;
    base = er_n;
    byte_io(CMD_BLOCK_ERASE);
    byte_io(BOOT_FIRST[15:8]);
    byte_io(BOOT_FIRST[23:16]);
    byte_io(CMD_CONFIRM);
    status(8'hB0, 8'h03);
    byte_io(CMD_CLEAR_STATUS);
    byte_io(CMD_BLOCK_ERASE);
    byte_io(8'h00);
    byte_io(8'h02);
    byte_io(CMD_CONFIRM);
    status(STATUS_RESET, 8'h03);
    check(24'(er_n - base), 24'h00_0001);
  endtask : t_erase

  // asynchronous session: status answered back to back, erase seen on the busy pin
  task automatic t_async();
    logic [15:0] q2;
    int base;
    base = er_n;
    u_host.o_rx = 1'b1;
    blank = 1'b1;
    reset_dut(3'b101, 1'b0);
    check(24'({act, sync, busy}), 24'h00_0004);
    u_host.uart_xfer(CMD_READ_STATUS, 2, q2);
    check(24'(q2), 24'h00_0080);
    u_host.uart_xfer(CMD_BLOCK_ERASE, 0, q2);
    u_host.uart_xfer(8'h00, 0, q2);
    u_host.uart_xfer(8'h02, 0, q2);
    u_host.uart_xfer(CMD_CONFIRM, 0, q2);
    check(24'(busy), 24'h00_0001);
    repeat (40) @(negedge mclk);
    check(24'({busy, tx}), 24'h00_0001);
    check(24'(er_n - base), 24'h00_0001);
  endtask : t_async

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge mclk);
    t_modes();
    t_gate();
    t_read();
    t_prog();
    t_erase();
    t_async();
    tally_and_finish();
  end
endmodule : test_serial_flash_programming_port
`default_nettype wire
